// File: hdl/algw_pkg.sv
// constants shared by the lightweight register gateway block
// Overview of operation
// RULE1 - each tagged gateway gets its own 32-bit register in the map
// RULE2 - decode bus address; update only the datapath port whose register matches
// RULE3 - address inputs are just wide enough to separate all registers
// RULE4 - offsets are unique per interface and multiples of four bytes
// RULE5 - first register of each interface sits at offset zero
// RULE6 - auto-placed registers take increasing offsets in alphabetical name order
// RULE7 - user-fixed offsets go first; auto registers fill the holes
// RULE8 - narrow gateways take the least significant register bits
// RULE9 - input-side registers are written by the bus and read back
// RULE10 - output-side registers are read-only over the bus
// RULE11 - each interface label forms its own slave with its own space
// RULE12 - each slave interface lives in one clock domain
// RULE13 - state changes only on the rising clock edge
// RULE14 - with clock enable low all flip-flops hold
// RULE15 - a channel transfer needs valid and ready; valid holds until then
// RULE16 - reset clears registers; every access answers OKAY
package algw_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 3; // RULE3
	localparam logic [ADDR_W-1:0] OFF_FIRST = 3'h0; // RULE4 RULE5 RULE6 RULE7
	localparam logic [ADDR_W-1:0] OFF_SECOND = 3'h4; // RULE4 RULE6 RULE7
	localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// File: hdl/algw_wr_slave.sv
// write side of one lightweight register slave: holds the input-side registers
`timescale 1ns/1ps
module algw_wr_slave #(
	parameter int GW_W = 32
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// write address and data channels
	input wire logic [algw_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [algw_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// stored words
	output logic [algw_pkg::DATA_W-1:0] word_first,
	output logic [algw_pkg::DATA_W-1:0] word_second
);
	// narrow gateways see only the low bits of their register
	localparam logic [algw_pkg::DATA_W-1:0] GW_MASK = {algw_pkg::DATA_W{1'b1}} >> (algw_pkg::DATA_W - GW_W); // RULE8

	generate
		if (GW_W < 1 || GW_W > algw_pkg::DATA_W)
		begin : g_bad_width
			$error("gateway width out of range");
		end
	endgenerate

	logic [algw_pkg::DATA_W-1:0] first_q; // RULE1
	logic [algw_pkg::DATA_W-1:0] second_q; // RULE1
	logic [algw_pkg::DATA_W-1:0] gw_first_q;
	logic [algw_pkg::DATA_W-1:0] gw_second_q;
	logic [algw_pkg::DATA_W-1:0] merged_first;
	logic [algw_pkg::DATA_W-1:0] merged_second;
	logic awready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// ready from a flop: one idle cycle per write, but no path from valid to ready
	wire accept = awvalid && wvalid && !awready_q && !bvalid_q; // RULE15
	wire hs = awvalid && wvalid && awready_q; // RULE15
	wire hit_first = awaddr == algw_pkg::OFF_FIRST; // RULE2
	wire hit_second = awaddr == algw_pkg::OFF_SECOND; // RULE2

	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign merged_first[8*b+7:8*b] = wstrb[b] ? wdata[8*b+7:8*b] : first_q[8*b+7:8*b];
			assign merged_second[8*b+7:8*b] = wstrb[b] ? wdata[8*b+7:8*b] : second_q[8*b+7:8*b];
		end
	endgenerate

	always_ff @(posedge clk) // RULE13
	begin
		if (rst)
		begin
			first_q <= algw_pkg::REG_RESET; // RULE16
			second_q <= algw_pkg::REG_RESET;
			gw_first_q <= algw_pkg::REG_RESET;
			gw_second_q <= algw_pkg::REG_RESET;
			awready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= algw_pkg::RESP_OKAY;
		end
		else if (ce) // RULE14
		begin
			awready_q <= accept;
			bresp_q <= algw_pkg::RESP_OKAY; // RULE16
			if (hs && hit_first)
			begin
				first_q <= merged_first; // RULE9
				gw_first_q <= merged_first & GW_MASK; // RULE8
			end
			if (hs && hit_second)
			begin
				second_q <= merged_second; // RULE9
				gw_second_q <= merged_second & GW_MASK; // RULE8
			end
			if (hs)
				bvalid_q <= 1'b1;
			else if (bready)
				bvalid_q <= 1'b0; // RULE15
		end
	end

	assign awready = awready_q;
	assign wready = awready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign word_first = gw_first_q;
	assign word_second = gw_second_q;
endmodule

// File: hdl/algw_rd_slave.sv
// read side of one lightweight register slave: muxes two words onto read data
`timescale 1ns/1ps
module algw_rd_slave (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// read address channel
	input wire logic [algw_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [algw_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// words to read
	input wire logic [algw_pkg::DATA_W-1:0] word_first,
	input wire logic [algw_pkg::DATA_W-1:0] word_second
);
	logic [algw_pkg::DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic arready_q;
	logic rvalid_q;

	// ready from a flop: one idle cycle per read, but no path from valid to ready
	wire accept = arvalid && !arready_q && !rvalid_q; // RULE15
	wire hs = arvalid && arready_q; // RULE15
	wire hit_first = araddr == algw_pkg::OFF_FIRST; // RULE2
	wire hit_second = araddr == algw_pkg::OFF_SECOND; // RULE2
	// unmapped addresses read zero, still answered okay
	wire [algw_pkg::DATA_W-1:0] sel = hit_first ? word_first : (hit_second ? word_second : algw_pkg::REG_RESET);

	always_ff @(posedge clk) // RULE13
	begin
		if (rst)
		begin
			rdata_q <= algw_pkg::REG_RESET; // RULE16
			rresp_q <= algw_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
		end
		else if (ce) // RULE14
		begin
			arready_q <= accept;
			rresp_q <= algw_pkg::RESP_OKAY; // RULE16
			if (hs)
			begin
				rdata_q <= sel; // RULE9
				rvalid_q <= 1'b1;
			end
			else if (rready)
				rvalid_q <= 1'b0; // RULE15
		end
	end

	assign arready = arready_q;
	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
endmodule

// File: hdl/algw_top.sv
// two lightweight register slaves: "in" drives datapath ports, "out" reads the separate datapath output ports
`timescale 1ns/1ps
module algw_top #(
	parameter int GW_W = 32
)(
	// one clock domain shared by both slaves
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// input-side slave write channels
	input wire logic [algw_pkg::ADDR_W-1:0] in_awaddr,
	input wire logic in_awvalid,
	output logic in_awready,
	input wire logic [algw_pkg::DATA_W-1:0] in_wdata,
	input wire logic [3:0] in_wstrb,
	input wire logic in_wvalid,
	output logic in_wready,
	output logic [1:0] in_bresp,
	output logic in_bvalid,
	input wire logic in_bready,
	// input-side slave read channels
	input wire logic [algw_pkg::ADDR_W-1:0] in_araddr,
	input wire logic in_arvalid,
	output logic in_arready,
	output logic [algw_pkg::DATA_W-1:0] in_rdata,
	output logic [1:0] in_rresp,
	output logic in_rvalid,
	input wire logic in_rready,
	// output-side slave read channels
	input wire logic [algw_pkg::ADDR_W-1:0] out_araddr,
	input wire logic out_arvalid,
	output logic out_arready,
	output logic [algw_pkg::DATA_W-1:0] out_rdata,
	output logic [1:0] out_rresp,
	output logic out_rvalid,
	input wire logic out_rready,
	// datapath ports
	output logic [algw_pkg::DATA_W-1:0] input_word_first,
	output logic [algw_pkg::DATA_W-1:0] input_word_second,
	input wire logic [algw_pkg::DATA_W-1:0] output_word_first,
	input wire logic [algw_pkg::DATA_W-1:0] output_word_second
);
	// fixed map: first at zero, second one word on, each label its own space
	// both slaves share clk, so nothing crosses between domains
	algw_wr_slave #(.GW_W(GW_W)) u_in_wr ( // RULE1 RULE12
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.awaddr(in_awaddr),
		.awvalid(in_awvalid),
		.awready(in_awready),
		.wdata(in_wdata),
		.wstrb(in_wstrb),
		.wvalid(in_wvalid),
		.wready(in_wready),
		.bresp(in_bresp),
		.bvalid(in_bvalid),
		.bready(in_bready),
		.word_first(input_word_first),
		.word_second(input_word_second)
	);

	algw_rd_slave u_in_rd (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.araddr(in_araddr),
		.arvalid(in_arvalid),
		.arready(in_arready),
		.rdata(in_rdata),
		.rresp(in_rresp),
		.rvalid(in_rvalid),
		.rready(in_rready),
		.word_first(input_word_first),
		.word_second(input_word_second)
	);

	// output side has no write channels at all, so the bus cannot write it
	algw_rd_slave u_out_rd ( // RULE10 RULE11
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.araddr(out_araddr),
		.arvalid(out_arvalid),
		.arready(out_arready),
		.rdata(out_rdata),
		.rresp(out_rresp),
		.rvalid(out_rvalid),
		.rready(out_rready),
		.word_first(output_word_first),
		.word_second(output_word_second)
	);
endmodule

// File: verif/algw_top_checker.sv
// handshake and response checks on the register gateway ports
`timescale 1ns/1ps
module algw_top_checker (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// input-side write channels
	input wire logic in_awvalid,
	input wire logic in_wvalid,
	input wire logic in_awready,
	input wire logic in_wready,
	input wire logic in_bvalid,
	input wire logic in_bready,
	input wire logic [1:0] in_bresp,
	// input-side read channels
	input wire logic in_arvalid,
	input wire logic in_arready,
	input wire logic in_rvalid,
	input wire logic in_rready,
	input wire logic [1:0] in_rresp,
	// output-side read channels
	input wire logic out_arvalid,
	input wire logic out_arready,
	input wire logic out_rvalid,
	input wire logic [1:0] out_rresp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wr_take_a: assert property (in_awready && in_awvalid && in_wvalid && ce |=> in_bvalid) else $error("write not answered");
	aw_accept_a: assert property (in_awvalid && in_wvalid && !in_awready && !in_bvalid && ce |=> in_awready) else $error("write not accepted");
	aw_drop_a: assert property (in_awready && ce |=> !in_awready) else $error("write ready held");
	w_pair_a: assert property (in_wready == in_awready) else $error("write ready split");
	ar_accept_a: assert property (in_arvalid && !in_arready && !in_rvalid && ce |=> in_arready) else $error("read not accepted");
	b_hold_a: assert property (in_bvalid && !(in_bready && ce) |=> in_bvalid) else $error("write answer dropped");
	b_okay_a: assert property (in_bvalid |-> in_bresp == 2'h0) else $error("write answer not okay");
	aw_ready_a: assert property (in_awready |-> in_awvalid && in_wvalid && !in_bvalid) else $error("write taken early");
	rd_take_a: assert property (in_arready && in_arvalid && ce |=> in_rvalid) else $error("read not answered");
	out_take_a: assert property (out_arready && out_arvalid && ce |=> out_rvalid) else $error("out read lost");
	r_okay_a: assert property (in_rvalid || out_rvalid |-> in_rresp == 2'h0 && out_rresp == 2'h0) else $error("read not okay");
	ce_hold_a: assert property (!ce |=> $stable(in_bvalid) && $stable(in_rvalid) && $stable(out_rvalid)
		&& $stable(in_awready) && $stable(in_arready) && $stable(out_arready)) else $error("moved with ce low");
endmodule
bind algw_top algw_top_checker chk (.*);

// File: verif/algw_dp_model.sv
// datapath model: feeds the read-only words from the written ones
`timescale 1ns/1ps
module algw_dp_model (
	// clock
	input wire logic clk,
	// datapath words
	input wire logic [31:0] in_first, in_second,
	output logic [31:0] word_first, word_second
);
	always_ff @(posedge clk)
	begin
		word_first <= in_first + 32'h1;
		word_second <= ~in_second;
	end
endmodule

// File: verif/algw_top_tb.sv
// register gateway testbench: bus tasks and directed sequence
`timescale 1ns/1ps
module algw_top_tb;
	logic clk = 0, rst = 1, ce = 1;
	logic [2:0] in_awaddr = 0, in_araddr = 0, out_araddr = 0;
	logic [31:0] in_wdata = 0;
	logic [3:0] in_wstrb = 4'hf;
	logic in_awvalid = 0, in_wvalid = 0, in_bready = 1, in_arvalid = 0, in_rready = 1, out_arvalid = 0, out_rready = 1;
	logic in_awready, in_wready, in_bvalid, in_arready, in_rvalid, out_arready, out_rvalid;
	logic [1:0] in_bresp, in_rresp, out_rresp;
	logic [31:0] in_rdata, out_rdata, input_word_first, input_word_second, output_word_first, output_word_second;
	int n_errors = 0, compares = 0;
	algw_top uut (.*);
	algw_dp_model dp (.clk(clk), .in_first(input_word_first), .in_second(input_word_second),
		.word_first(output_word_first), .word_second(output_word_second));
	always #12.5 clk = ~clk;
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		in_awaddr <= a;
		in_wdata <= d;
		in_awvalid <= 1'h1;
		in_wvalid <= 1'h1;
		do @(negedge clk); while (in_awready !== 1'h1);
		check({31'h0, in_wready}, 32'h1);
		@(posedge clk);
		in_awvalid <= 1'h0;
		in_wvalid <= 1'h0;
		@(negedge clk);
		check({29'h0, in_bvalid, in_bresp}, 32'h4);
		@(posedge clk);
	endtask
	task automatic rd(input bit o, input logic [2:0] a, input logic [31:0] e);
		in_araddr <= a;
		out_araddr <= a;
		in_arvalid <= !o;
		out_arvalid <= o;
		do @(negedge clk); while ((o ? out_arready : in_arready) !== 1'h1);
		@(posedge clk);
		in_arvalid <= 1'h0;
		out_arvalid <= 1'h0;
		@(negedge clk);
		check(o ? out_rdata : in_rdata, e);
		check({29'h0, (o ? out_rvalid : in_rvalid), (o ? out_rresp : in_rresp)}, 32'h4);
		@(posedge clk);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd(0, 3'h0, 32'h0);
		rd(0, 3'h4, 32'h0);
		wr(3'h0, 32'h89abcdef);
		check(input_word_first, 32'h89abcdef);
		check(input_word_second, 32'h0);
		wr(3'h4, 32'h01234567);
		check(input_word_first, 32'h89abcdef);
		check(input_word_second, 32'h01234567);
		wr(3'h2, 32'hffffffff);
		check(input_word_first ^ input_word_second, 32'h88888888);
		rd(0, 3'h0, 32'h89abcdef);
		rd(0, 3'h4, 32'h01234567);
		rd(0, 3'h2, 32'h0);
		rd(1, 3'h0, 32'h89abcdf0);
		rd(1, 3'h4, 32'hfedcba98);
		in_wstrb <= 4'h3;
		wr(3'h0, 32'h5555aaaa);
		in_wstrb <= 4'hf;
		check(input_word_first, 32'h89abaaaa);
		ce <= 1'h0;
		in_arvalid <= 1'h1;
		repeat (3) @(posedge clk);
		check({30'h0, in_arready, in_rvalid}, 32'h0);
		ce <= 1'h1;
		rd(0, 3'h4, 32'h01234567);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		check(input_word_first | input_word_second, 32'h0);
		check({29'h0, in_bvalid, in_rvalid, in_arready}, 32'h0);
		finish_test;
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		n_errors++;
		finish_test;
	end
endmodule
